// [include/cam_pkg.sv]
/*
 * Shared constants and carrier types of the masked content-addressable memory.
 * Assumes a single clock domain and a synchronous, active-low reset in every user.
 */
// Notes on behaviour
// - Store 32 entries of 32 bits; compare one key against all of them.
// - Writes may mark single stored bits as don't-care besides zero and one.
// - Don't-care bits are ignored when comparing; they never decide a match.
// - Encoded configuration returns the binary index of the matching entry.
// - Unencoded configuration drives one high line per matching entry on 16 lines.
// - The 32 match lines leave over 16 lines in two consecutive cycles.
// - Unencoded results show every matching entry, entries 0-15 one cycle before entries 16-31.
// - Contents preload from constants at reset and are writable in operation.
// - A plain write takes two cycles; the writer holds request and data throughout.
// - A write carrying don't-care bits takes three cycles, request held throughout.
`default_nettype none

package cam_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int unsigned ENTRIES   = 32;
    localparam int unsigned WIDTH     = 32;
    localparam int unsigned HALF      = 16;
    localparam int unsigned ADDR_W    = 5;

    // ****************************************************************
    // Write timing, in clock cycles
    // ****************************************************************
    localparam logic [1:0]  WR_CYCLES_PLAIN  = 2'h2;
    localparam logic [1:0]  WR_CYCLES_MASKED = 2'h3;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [WIDTH-1:0]  RESET_WORD = 32'h0000_0000;
    localparam logic [WIDTH-1:0]  RESET_DC   = 32'hFFFF_FFFF;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [WIDTH-1:0]  data;
        logic              masked;
        logic [WIDTH-1:0]  dont_care;
    } wr_req_t;

    typedef struct packed {
        logic              en;
        logic [WIDTH-1:0]  key;
    } search_req_t;

endpackage

`default_nettype wire

// [hdl/cam_entry.sv]
/*
 * One stored word of the masked content-addressable memory with its comparator.
 * Assumes the parent commits a write with a single-cycle strobe and supplies preload values.
 */
`default_nettype none

module cam_entry #(
    parameter logic [31:0] INIT_WORD = 32'h0000_0000,
    parameter logic [31:0] INIT_DC   = 32'hFFFF_FFFF
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_commit,
    input  wire logic [31:0] i_word,
    input  wire logic [31:0] i_dont_care,
    input  wire logic [31:0] i_key,
    output logic             o_match
);

    logic [31:0] word_q;
    logic [31:0] dc_q;

    // ****************************************************************
    // Storage
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            word_q <= INIT_WORD;
            dc_q   <= INIT_DC;
        end else if (i_commit) begin
            word_q <= i_word;
            dc_q   <= i_dont_care;
        end
    end

    // ****************************************************************
    // Compare
    // ****************************************************************
    assign o_match = &((~(word_q ^ i_key)) | dc_q);

endmodule

`default_nettype wire

// [hdl/masked_cam.sv]
/*
 * Masked content-addressable memory, 32 words of 32 bits, with encoded or
 * unencoded search results and multi-cycle writes.
 * Assumes user logic drives requests synchronous to I_CLK, holds a write for its
 * full length, and in encoded configuration never stores duplicate entries.
 */
`default_nettype none

module masked_cam #(
    parameter logic [cam_pkg::ENTRIES*cam_pkg::WIDTH-1:0] INIT_WORDS = '0,
    parameter logic [cam_pkg::ENTRIES*cam_pkg::WIDTH-1:0] INIT_DCS   = '1
) (
    input  wire logic                          I_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_ENCODED,
    input  wire cam_pkg::wr_req_t              I_WR,
    input  wire cam_pkg::search_req_t          I_SEARCH,
    output logic                               O_WR_DONE,
    output logic                               O_SEARCH_READY,
    output logic                               O_RESULT_VALID,
    output logic                               O_MATCH_FOUND,
    output logic [cam_pkg::ADDR_W-1:0]         O_MATCH_ADDR,
    output logic [cam_pkg::HALF-1:0]           O_HIT_LINES,
    output logic                               O_HIT_UPPER
);

    typedef enum logic {
        SRCH_IDLE,
        SRCH_UPPER
    } srch_state_t;

    srch_state_t                 srch_q;
    srch_state_t                 srch_d;
    logic [1:0]                  wr_cnt_q;
    logic [1:0]                  wr_need;
    logic                        wr_commit;
    logic                        wr_steady;
    logic [cam_pkg::ADDR_W-1:0]  wr_addr_q;
    logic                        wr_masked_q;
    logic [cam_pkg::ENTRIES-1:0] match_vec;
    logic [cam_pkg::ENTRIES-1:0] commit_vec;
    logic [cam_pkg::HALF-1:0]    upper_q;
    logic                        search_take;
    logic                        any_match;
    logic [cam_pkg::ADDR_W-1:0]  first_idx;

    // ****************************************************************
    // Entry array
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < cam_pkg::ENTRIES; g++) begin : g_entry
            cam_entry #(
                .INIT_WORD (INIT_WORDS[g*cam_pkg::WIDTH +: cam_pkg::WIDTH]),
                .INIT_DC   (INIT_DCS[g*cam_pkg::WIDTH +: cam_pkg::WIDTH])
            ) u_entry (
                .i_clk       (I_CLK),
                .i_rst_n     (I_RST_N),
                .i_commit    (commit_vec[g]),
                .i_word      (I_WR.data),
                .i_dont_care (I_WR.masked ? I_WR.dont_care : '0),
                .i_key       (I_SEARCH.key),
                .o_match     (match_vec[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Write sequencing
    // ****************************************************************
    assign wr_need   = I_WR.masked ? cam_pkg::WR_CYCLES_MASKED
                                   : cam_pkg::WR_CYCLES_PLAIN;
    // A write whose address or mode moves mid-way restarts with the new request
    assign wr_steady = (wr_cnt_q == 2'h0)
                       || ((I_WR.addr == wr_addr_q) && (I_WR.masked == wr_masked_q));
    assign wr_commit = I_WR.en && wr_steady && (wr_cnt_q == wr_need - 2'h1);

    always_comb begin
        commit_vec = '0;
        if (wr_commit) begin
            commit_vec[I_WR.addr] = 1'b1;
        end
    end

    // Dropping the request before its last cycle abandons the write
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            wr_cnt_q <= 2'h0;
        end else if (!I_WR.en || wr_commit) begin
            wr_cnt_q <= 2'h0;
        end else if (!wr_steady) begin
            wr_cnt_q <= 2'h1;
        end else begin
            wr_cnt_q <= wr_cnt_q + 2'h1;
        end
    end

    // Address and mode of the write being counted
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            wr_addr_q   <= '0;
            wr_masked_q <= 1'b0;
        end else if (I_WR.en && !wr_commit) begin
            wr_addr_q   <= I_WR.addr;
            wr_masked_q <= I_WR.masked;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_WR_DONE <= 1'b0;
        end else begin
            O_WR_DONE <= wr_commit;
        end
    end

    // ****************************************************************
    // Priority encoder, lowest index wins
    // ****************************************************************
    always_comb begin
        first_idx = '0;
        any_match = 1'b0;
        for (int i = cam_pkg::ENTRIES - 1; i >= 0; i--) begin
            if (match_vec[i]) begin
                first_idx = i[cam_pkg::ADDR_W-1:0];
                any_match = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Search sequencing
    // ****************************************************************
    assign search_take = I_SEARCH.en && (srch_q == SRCH_IDLE);

    always_comb begin
        case (srch_q)
            SRCH_IDLE: begin
                srch_d = (search_take && !I_ENCODED) ? SRCH_UPPER : SRCH_IDLE;
            end
            SRCH_UPPER: begin
                srch_d = SRCH_IDLE;
            end
            default: begin
                srch_d = SRCH_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            srch_q <= SRCH_IDLE;
        end else begin
            srch_q <= srch_d;
        end
    end

    // Ready is low for the cycle that carries the lower half
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_SEARCH_READY <= 1'b1;
        end else begin
            O_SEARCH_READY <= (srch_d == SRCH_IDLE);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            upper_q <= '0;
        end else if (search_take) begin
            upper_q <= match_vec[cam_pkg::ENTRIES-1:cam_pkg::HALF];
        end
    end

    // ****************************************************************
    // Result outputs
    // ****************************************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_RESULT_VALID <= 1'b0;
        end else begin
            O_RESULT_VALID <= search_take || (srch_q == SRCH_UPPER);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_HIT_LINES <= '0;
        end else if (srch_q == SRCH_UPPER) begin
            O_HIT_LINES <= upper_q;
        end else if (search_take && !I_ENCODED) begin
            O_HIT_LINES <= match_vec[cam_pkg::HALF-1:0];
        end else begin
            O_HIT_LINES <= '0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_HIT_UPPER <= 1'b0;
        end else begin
            O_HIT_UPPER <= (srch_q == SRCH_UPPER);
        end
    end

    // Encoded result; meaningful only without duplicate entries
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_MATCH_FOUND <= 1'b0;
        end else if (search_take && I_ENCODED) begin
            O_MATCH_FOUND <= any_match;
        end else if (search_take || srch_q == SRCH_UPPER) begin
            O_MATCH_FOUND <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_MATCH_ADDR <= '0;
        end else if (search_take && I_ENCODED) begin
            O_MATCH_ADDR <= first_idx;
        end else if (search_take || srch_q == SRCH_UPPER) begin
            O_MATCH_ADDR <= '0;
        end
    end

endmodule

`default_nettype wire

// [tb/masked_cam_asserts.sv]
/* Port checker of the masked CAM: write commit timing and search result framing.
   Assumes one clock domain with synchronous active-low reset; bound below. */
`default_nettype none
module masked_cam_asserts (
    input wire logic                  I_CLK,
    input wire logic                  I_RST_N,
    input wire logic                  I_ENCODED,
    input wire cam_pkg::wr_req_t      I_WR,
    input wire cam_pkg::search_req_t  I_SEARCH,
    input wire logic                  O_WR_DONE,
    input wire logic                  O_SEARCH_READY,
    input wire logic                  O_RESULT_VALID,
    input wire logic                  O_MATCH_FOUND,
    input wire logic [4:0]            O_MATCH_ADDR,
    input wire logic [15:0]           O_HIT_LINES,
    input wire logic                  O_HIT_UPPER
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    a_plain_commit: assert property (O_WR_DONE |-> $past(I_WR.en) && $past(I_WR.en, 2))
        else $error("write done without two held cycles");
    a_masked_commit: assert property (O_WR_DONE && $past(I_WR.masked) |-> $past(I_WR.en, 3))
        else $error("masked write done without three held cycles");
    a_done_pulse: assert property (O_WR_DONE |=> !O_WR_DONE)
        else $error("write done longer than one cycle");
    a_search_answer: assert property (I_SEARCH.en && O_SEARCH_READY
        |=> O_RESULT_VALID && !O_HIT_UPPER)
        else $error("no result one cycle after search");
    a_upper_half: assert property (I_SEARCH.en && O_SEARCH_READY && !I_ENCODED
        |=> !O_SEARCH_READY ##1 (O_SEARCH_READY && O_HIT_UPPER && O_RESULT_VALID))
        else $error("upper half not in second result cycle");
    a_unenc_found: assert property (I_SEARCH.en && O_SEARCH_READY && !I_ENCODED
        |=> !O_MATCH_FOUND)
        else $error("match found set on unencoded result");
    a_nomatch_addr: assert property (I_SEARCH.en && O_SEARCH_READY && I_ENCODED ##1 !O_MATCH_FOUND
        |-> O_MATCH_ADDR == 5'h00)
        else $error("address not zero without match");
    a_lines_idle: assert property (!O_RESULT_VALID |-> O_HIT_LINES == 16'h0000)
        else $error("hit lines set outside result cycle");
endmodule
bind masked_cam masked_cam_asserts u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ENCODED(I_ENCODED),
    .I_WR(I_WR), .I_SEARCH(I_SEARCH), .O_WR_DONE(O_WR_DONE), .O_SEARCH_READY(O_SEARCH_READY),
    .O_RESULT_VALID(O_RESULT_VALID), .O_MATCH_FOUND(O_MATCH_FOUND), .O_MATCH_ADDR(O_MATCH_ADDR),
    .O_HIT_LINES(O_HIT_LINES), .O_HIT_UPPER(O_HIT_UPPER));
`default_nettype wire

// [tb/cam_user_model.sv]
/* User-side model issuing held multi-cycle writes to the masked CAM.
   Assumes the bench pulses i_go for one cycle while o_busy is low. */
`default_nettype none
module cam_user_model (
    input  wire logic           i_clk,
    input  wire logic           i_rst_n,
    input  wire logic           i_go,
    input  wire logic [4:0]     i_addr,
    input  wire logic [31:0]    i_data,
    input  wire logic           i_masked,
    input  wire logic [31:0]    i_dc,
    output var cam_pkg::wr_req_t o_wr,
    output logic                o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    cam_pkg::wr_req_t wr_q = '0;
    logic [1:0]       left_q = 2'h0;
    assign o_wr = wr_q;
    assign o_busy = (left_q != 2'h0);
    // Released fields show inverted values so stale data is never mistaken for held data
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            left_q <= 2'h0;
            wr_q.en <= 1'b0;
        end else if (i_go && left_q == 2'h0) begin
            wr_q <= '{1'b1, i_addr, i_data, i_masked, i_dc};
            left_q <= i_masked ? cam_pkg::WR_CYCLES_MASKED : cam_pkg::WR_CYCLES_PLAIN;
        end else if (left_q != 2'h0) begin
            left_q <= left_q - 2'h1;
            if (left_q == 2'h1) begin
                wr_q <= '{1'b0, ~wr_q.addr, ~wr_q.data, ~wr_q.masked, ~wr_q.dont_care};
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb_masked_cam.sv]
/* Self-checking bench of the masked CAM: writes, encoded and unencoded searches.
   Assumes the package, design, checker and user model are compiled first. */
`default_nettype none
module tb_masked_cam;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0, rst_n = 1'b0, enc = 1'b1, go = 1'b0, w_m = 1'b0;
    logic [4:0]           w_a = 5'h00;
    logic [31:0]          w_d = 32'h0, w_c = 32'h0;
    cam_pkg::search_req_t srch = '0;
    cam_pkg::wr_req_t     wr;
    logic                 busy, done, rdy, vld, found, upper;
    logic [4:0]           maddr;
    logic [15:0]          lines, lo, hi;
    int                   mismatches = 0;
    int                   check_count = 0;
    always #2.5 clk = ~clk;
    masked_cam DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_ENCODED(enc), .I_WR(wr), .I_SEARCH(srch),
        .O_WR_DONE(done), .O_SEARCH_READY(rdy), .O_RESULT_VALID(vld), .O_MATCH_FOUND(found),
        .O_MATCH_ADDR(maddr), .O_HIT_LINES(lines), .O_HIT_UPPER(upper));
    cam_user_model u_user (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_addr(w_a), .i_data(w_d),
        .i_masked(w_m), .i_dc(w_c), .o_wr(wr), .o_busy(busy));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_word(input logic [4:0] a, input logic [31:0] d, input logic m,
                           input logic [31:0] c);
        @(posedge clk);
        {w_a, w_d, w_m, w_c, go} <= {a, d, m, c, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (int k = 0; k < 4 && busy; k++) begin
            @(posedge clk);
            #1;
        end
        chk("wr_done", 32'h1, 32'(done));
    endtask
    task automatic search(input logic [31:0] key, input logic e);
        @(posedge clk);
        srch <= '{1'b1, key};
        enc <= e;
        @(posedge clk);
        srch.en <= 1'b0;
        #1;
        chk("valid", 32'h1, 32'(vld));
        lo = lines;
        hi = 16'h0000;
        if (!e) begin
            @(posedge clk);
            #1;
            chk("upper", 32'h1, 32'(upper));
            hi = lines;
        end
    endtask
    task automatic t_fill();
        for (int i = 0; i < 32; i++) wr_word(5'(i), 32'hC0DE_0000 + i, 1'b0, 32'h0);
        for (int i = 31; i >= 0; i--) begin
            search(32'hC0DE_0000 + i, 1'b1);
            chk("addr", i, 32'(maddr));
            chk("found", 32'h1, 32'(found));
        end
        search(32'hC0DE_0100, 1'b1);
        chk("nomatch", 32'h0, 32'(found));
        chk("nomatch_addr", 32'h0, 32'(maddr));
    endtask
    task automatic t_mask();
        wr_word(5'h07, 32'h1234_5600, 1'b1, 32'h0000_00FF);
        wr_word(5'h14, 32'h1234_0078, 1'b1, 32'h0000_FF00);
        search(32'h1234_5678, 1'b0);
        chk("lines_lo", 32'h0080, 32'(lo));
        chk("lines_hi", 32'h0010, 32'(hi));
        search(32'h1235_5678, 1'b0);
        chk("cared_bit", 32'h0, {lo, hi});
        search(32'h1234_56AA, 1'b1);
        chk("masked_addr", 32'h7, 32'(maddr));
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        search(32'hDEAD_BEEF, 1'b1);
        chk("preload", 32'h1, 32'({maddr, found}));
        t_fill();
        t_mask();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
